// >>> common/rbg_pkg.sv
`default_nettype none
package rbg_pkg;
    // Sizes
    localparam int NBR = 55;
    localparam int NBASE = 12;
    localparam int NSUB = 24;
    localparam int NCOLD = 5;
    localparam int NSTG = 5;
    localparam int NSTR = NSTG + NSUB;
    // Reset stretch length in core_clk cycles
    localparam logic [3:0] RST_STRETCH_CYC = 4'h8;
    // First branch index of each base clock, last entry is NBR
    localparam int BASE_FIRST [NBASE+1] = '{0, 1, 21, 22, 29, 40, 41, 43, 46, 50, 53, 54, 55};
    // Branch control bit masks and reset values
    localparam logic [NBR-1:0] RUN_WR_MASK = 55'h7f_ffff_ffdf_fff0;
    localparam logic [NBR-1:0] AUTO_WR_MASK = 55'h7f_ffff_ffff_fffe;
    localparam logic [NBR-1:0] WAKE_WR_MASK = 55'h7f_ffff_ffff_fffe;
    localparam logic [NBR-1:0] RUN_RST = 55'h7f_ffff_ffff_ffff;
    localparam logic [NBR-1:0] AUTO_RST = 55'h00_0000_0000_0000;
    localparam logic [NBR-1:0] WAKE_RST = 55'h00_0000_0000_0000;
    // Register offsets
    localparam logic [11:0] OFF_RST_SRC = 12'h000;
    localparam logic [11:0] OFF_RST_KEY = 12'h004;
    localparam logic [11:0] OFF_RST_CTRL = 12'h008;
    localparam logic [11:0] OFF_RST_STAT = 12'h00c;
    localparam logic [11:0] OFF_PD_CTRL = 12'h010;
    localparam logic [11:0] OFF_BASE_STAT = 12'h014;
    localparam logic [3:0] OFF_BR_PAGE = 4'h1;
    // Field positions
    localparam int BR_RUN_BIT = 0;
    localparam int BR_AUTO_BIT = 1;
    localparam int BR_WAKE_BIT = 2;
    localparam int BR_ON_BIT = 3;
    localparam int SRC_POR_BIT = 0;
    localparam int SRC_PIN_BIT = 1;
    localparam int SRC_WDT_BIT = 2;
    localparam int SRC_SW_BIT = 3;
    localparam int PD_MODE_BIT = 0;
    // Reset values and unlock key
    localparam logic [3:0] RST_SRC_RST = 4'h1;
    localparam logic [31:0] RST_KEY_VAL = 32'h0000_a5c3;
endpackage
`default_nettype wire

// >>> design/rbg_top.sv
// Contract
// - Each reset output ORs its sources
// - Power-on reset comes only from detector
// - Generator reset from power-on or pin
// - Control reset from generator reset or watchdog
// - Cold reset follows control reset
// - Warm reset follows cold reset
// - Memory and config resets derive from cold
// - Other subsystem resets derive from warm
// - Reset pin active low, pulled up
// - Resets self-stretch; subsystems individually resettable
// - Reset source recorded for software
// - Reset control write-protected by key
// - Branch clocks switched by own register
// - Tied bits read fixed, ignore writes
// - Safe and vital clocks have tied bits
// - Other branch bits fully read-write
// - Wake-up restarts clocks with wake bit
// - Power-down stops selected enabled clocks
// - Auto bit uses master-disable handshake
// - Per-base all-branches-off status
// - Branch clock fixed to one base
`timescale 1ns/100ps
`default_nettype none
module rbg_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Reset and wake-up sources
    input wire logic rst_pin_b,
    input wire logic wdt_rst_req,
    input wire logic wake_evt,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Reset outputs
    output logic por_rst,
    output logic generator_internal_reset,
    output logic clock_control_reset,
    output logic cold_reset,
    output logic warm_reset,
    output logic [rbg_pkg::NSUB-1:0] sub_rst,
    // Clocks
    input wire logic [rbg_pkg::NBASE-1:0] base_clk,
    output logic [rbg_pkg::NBR-1:0] branch_clk,
    output logic [rbg_pkg::NBASE-1:0] base_idle,
    // Bus master disable handshake
    output logic [rbg_pkg::NBR-1:0] mstr_dis_req,
    input wire logic [rbg_pkg::NBR-1:0] mstr_dis_ack
);

    // Pin synchronisers
    logic pin_s1_r;
    logic pin_s2_r;
    logic wake_s1_r;
    logic wake_s2_r;
    // Synchronised levels
    wire pin_rst = ~pin_s2_r;
    wire wake_lvl = wake_s2_r;

    // Pin idles high, so reset state is high
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else if (clk_en) begin
            pin_s1_r <= rst_pin_b;
            pin_s2_r <= pin_s1_r;
        end
    end

    // Wake-up idles low
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_s1_r <= 1'b0;
            wake_s2_r <= 1'b0;
        end else if (clk_en) begin
            wake_s1_r <= wake_evt;
            wake_s2_r <= wake_s1_r;
        end
    end

    // APB decode
    wire setup = psel & ~penable;
    wire acc = psel & penable;
    wire wr = acc & pwrite;

    // Register hits
    wire hit_src = paddr == rbg_pkg::OFF_RST_SRC;
    wire hit_key = paddr == rbg_pkg::OFF_RST_KEY;
    wire hit_ctrl = paddr == rbg_pkg::OFF_RST_CTRL;
    wire hit_stat = paddr == rbg_pkg::OFF_RST_STAT;
    wire hit_pd = paddr == rbg_pkg::OFF_PD_CTRL;
    wire hit_base = paddr == rbg_pkg::OFF_BASE_STAT;
    wire [5:0] br_idx = paddr[7:2];
    wire br_page = paddr[11:8] == rbg_pkg::OFF_BR_PAGE;
    wire br_align = paddr[1:0] == 2'b00;
    wire br_in = br_idx < 6'(rbg_pkg::NBR);
    wire hit_br = br_page & br_align & br_in;
    wire hit_any = hit_src | hit_key | hit_ctrl | hit_stat | hit_pd | hit_base | hit_br;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit_any;

    // Reset stretchers: power-on, generator, control, cold, warm, subsystems
    logic [rbg_pkg::NSTR-1:0] str_src;
    logic [rbg_pkg::NSTR-1:0] str_out;
    logic [rbg_pkg::NSUB-1:0] sw_pulse_r;

    // Cascade sources
    assign str_src[0] = 1'b0;
    assign str_src[1] = str_out[0] | pin_rst;
    assign str_src[2] = str_out[1] | wdt_rst_req;
    assign str_src[3] = str_out[2];
    assign str_src[4] = str_out[3];

    // Subsystem sources, cold or warm
    genvar gs;
    generate
        for (gs = 0; gs < rbg_pkg::NSUB; gs++) begin : g_sub
            if (gs < rbg_pkg::NCOLD) begin : g_cold
                assign str_src[rbg_pkg::NSTG+gs] = str_out[3] | sw_pulse_r[gs];
            end else begin : g_warm
                assign str_src[rbg_pkg::NSTG+gs] = str_out[4] | sw_pulse_r[gs];
            end
        end
        for (gs = 0; gs < rbg_pkg::NSTR; gs++) begin : g_str
            // Stretch counter per reset
            logic [3:0] cnt_r;
            logic [3:0] cnt_nxt;
            always_comb begin
                if (str_src[gs]) begin
                    cnt_nxt = rbg_pkg::RST_STRETCH_CYC;
                end else if (cnt_r != 4'h0) begin
                    cnt_nxt = cnt_r - 4'h1;
                end else begin
                    cnt_nxt = 4'h0;
                end
            end
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_r <= rbg_pkg::RST_STRETCH_CYC;
                end else if (clk_en) begin
                    cnt_r <= cnt_nxt;
                end
            end
            assign str_out[gs] = cnt_r != 4'h0;
        end
    endgenerate

    // Reset outputs
    assign por_rst = str_out[0];
    assign generator_internal_reset = str_out[1];
    assign clock_control_reset = str_out[2];
    assign cold_reset = str_out[3];
    assign warm_reset = str_out[4];
    assign sub_rst = str_out[rbg_pkg::NSTR-1:rbg_pkg::NSTG];

    // Cascade resets clearing this block's own state
    wire gen_rst = str_out[1];
    wire cc_rst = str_out[2];

    // Reset control protection and source record
    logic unlock_r;
    logic unlock_nxt;
    logic [3:0] src_r;
    logic [3:0] src_nxt;
    logic [rbg_pkg::NSUB-1:0] sw_pulse_nxt;
    wire key_wr = wr & hit_key;
    wire key_ok = pwdata == rbg_pkg::RST_KEY_VAL;
    wire ctrl_wr = wr & hit_ctrl & unlock_r;
    wire sw_src = ctrl_wr & (|pwdata[rbg_pkg::NSUB-1:0]);
    wire [3:0] src_set = {sw_src, wdt_rst_req, pin_rst, 1'b0};
    wire [3:0] src_clr = (wr & hit_src) ? pwdata[3:0] : 4'h0;
    assign src_nxt = (src_r & ~src_clr) | src_set;
    // Wrong key or any control write relocks
    assign unlock_nxt = key_wr ? key_ok : ((wr & hit_ctrl) ? 1'b0 : unlock_r);
    assign sw_pulse_nxt = ctrl_wr ? pwdata[rbg_pkg::NSUB-1:0] : '0;

    // Source record survives the cascade
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            src_r <= rbg_pkg::RST_SRC_RST;
        end else if (clk_en) begin
            src_r <= src_nxt;
        end
    end

    // Generator reset relocks and drops pulses
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            unlock_r <= 1'b0;
            sw_pulse_r <= '0;
        end else if (clk_en && gen_rst) begin
            unlock_r <= 1'b0;
            sw_pulse_r <= '0;
        end else if (clk_en) begin
            unlock_r <= unlock_nxt;
            sw_pulse_r <= sw_pulse_nxt;
        end
    end

    // Power-down mode, cleared by wake-up
    logic pd_r;
    wire pd_wr = wr & hit_pd;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pd_r <= 1'b0;
        end else if (clk_en && cc_rst) begin
            pd_r <= 1'b0;
        end else if (clk_en) begin
            // Wake wins over a power-down write
            if (wake_lvl) begin
                pd_r <= 1'b0;
            end else if (pd_wr) begin
                pd_r <= pwdata[rbg_pkg::PD_MODE_BIT];
            end
        end
    end

    // Branch configuration
    logic [rbg_pkg::NBR-1:0] run_r;
    logic [rbg_pkg::NBR-1:0] auto_r;
    logic [rbg_pkg::NBR-1:0] wake_r;
    logic [rbg_pkg::NBR-1:0] en_r;
    logic [rbg_pkg::NBR-1:0] req_r;
    logic [rbg_pkg::NBR-1:0] gate_l;
    // Tied run bits read one
    wire [rbg_pkg::NBR-1:0] run_rd = run_r | ~rbg_pkg::RUN_WR_MASK;
    wire [rbg_pkg::NBR-1:0] auto_rd = auto_r & rbg_pkg::AUTO_WR_MASK;
    wire [rbg_pkg::NBR-1:0] wake_rd = wake_r & rbg_pkg::WAKE_WR_MASK;

    genvar gb;
    generate
        for (gb = 0; gb < rbg_pkg::NBR; gb++) begin : g_br
            wire sel = wr & hit_br & (br_idx == 6'(gb));
            wire want = run_rd[gb] & ~(pd_r & wake_rd[gb]);
            wire ack_seen = req_r[gb] & mstr_dis_ack[gb];

            // Register write, tied bits keep reset value
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    run_r[gb] <= rbg_pkg::RUN_RST[gb];
                    auto_r[gb] <= rbg_pkg::AUTO_RST[gb];
                    wake_r[gb] <= rbg_pkg::WAKE_RST[gb];
                end else if (clk_en && cc_rst) begin
                    run_r[gb] <= rbg_pkg::RUN_RST[gb];
                    auto_r[gb] <= rbg_pkg::AUTO_RST[gb];
                    wake_r[gb] <= rbg_pkg::WAKE_RST[gb];
                end else if (clk_en && sel) begin
                    run_r[gb] <= rbg_pkg::RUN_WR_MASK[gb] ? pwdata[rbg_pkg::BR_RUN_BIT]
                        : rbg_pkg::RUN_RST[gb];
                    auto_r[gb] <= pwdata[rbg_pkg::BR_AUTO_BIT] & rbg_pkg::AUTO_WR_MASK[gb];
                    wake_r[gb] <= pwdata[rbg_pkg::BR_WAKE_BIT] & rbg_pkg::WAKE_WR_MASK[gb];
                end
            end

            // Enable and master-disable handshake
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    en_r[gb] <= 1'b1;
                    req_r[gb] <= 1'b0;
                end else if (clk_en && cc_rst) begin
                    en_r[gb] <= 1'b1;
                    req_r[gb] <= 1'b0;
                end else if (clk_en) begin
                    if (want) begin
                        en_r[gb] <= 1'b1;
                        req_r[gb] <= 1'b0;
                    end else if (en_r[gb] & auto_rd[gb]) begin
                        // Auto branch waits for the master to drain
                        req_r[gb] <= 1'b1;
                        en_r[gb] <= ~ack_seen;
                    end else begin
                        en_r[gb] <= 1'b0;
                        req_r[gb] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
    assign mstr_dis_req = req_r;

    // Clock gates, each branch wired to its own base
    genvar gk;
    genvar gj;
    generate
        for (gk = 0; gk < rbg_pkg::NBASE; gk++) begin : g_base
            localparam int LO = rbg_pkg::BASE_FIRST[gk];
            localparam int HI = rbg_pkg::BASE_FIRST[gk+1] - 1;
            // All branches of one base off
            assign base_idle[gk] = ~|en_r[HI:LO];
            for (gj = LO; gj <= HI; gj++) begin : g_gate
                // Latch open only while base clock low
                always_latch begin
                    if (!base_clk[gk]) begin
                        gate_l[gj] = en_r[gj];
                    end
                end
                assign branch_clk[gj] = base_clk[gk] & gate_l[gj];
            end
        end
    endgenerate

    // Read data, captured in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_src) begin
            rd_mux[3:0] = src_r;
        end else if (hit_stat) begin
            rd_mux[rbg_pkg::NSUB-1:0] = sub_rst;
        end else if (hit_pd) begin
            rd_mux[rbg_pkg::PD_MODE_BIT] = pd_r;
        end else if (hit_base) begin
            rd_mux[rbg_pkg::NBASE-1:0] = base_idle;
        end else if (hit_br) begin
            // Branch word: run, auto, wake, on
            rd_mux[rbg_pkg::BR_RUN_BIT] = run_rd[br_idx];
            rd_mux[rbg_pkg::BR_AUTO_BIT] = auto_rd[br_idx];
            rd_mux[rbg_pkg::BR_WAKE_BIT] = wake_rd[br_idx];
            rd_mux[rbg_pkg::BR_ON_BIT] = en_r[br_idx];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && setup) begin
            prdata <= rd_mux;
        end
    end

endmodule // rbg_top
`default_nettype wire

// >>> sim/rbg_props.sv
`timescale 1ns/100ps
`default_nettype none
module rbg_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Sources and bus
    input wire logic rst_pin_b,
    input wire logic wdt_rst_req,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pslverr,
    // Resets
    input wire logic por_rst,
    input wire logic generator_internal_reset,
    input wire logic clock_control_reset,
    input wire logic cold_reset,
    input wire logic warm_reset,
    input wire logic [rbg_pkg::NSUB-1:0] sub_rst,
    // Clocks
    input wire logic [rbg_pkg::NBASE-1:0] base_clk,
    input wire logic [rbg_pkg::NBR-1:0] branch_clk,
    input wire logic [rbg_pkg::NBASE-1:0] base_idle
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_por; por_rst |=> generator_internal_reset; endproperty
    a_por: assert property (p_por) else $error("por not passed on");
    property p_pin; !rst_pin_b [*3] |-> ##[1:2] generator_internal_reset; endproperty
    a_pin: assert property (p_pin) else $error("pin reset missed");
    property p_gen; generator_internal_reset |=> clock_control_reset; endproperty
    a_gen: assert property (p_gen) else $error("control reset missed");
    property p_wdt; wdt_rst_req |=> clock_control_reset; endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
    property p_cold; clock_control_reset |=> cold_reset; endproperty
    a_cold: assert property (p_cold) else $error("cold reset missed");
    property p_warm; cold_reset |=> warm_reset; endproperty
    a_warm: assert property (p_warm) else $error("warm reset missed");
    property p_csub; cold_reset |-> ##[1:2] (&sub_rst[4:0]); endproperty
    a_csub: assert property (p_csub) else $error("cold subsystem reset missed");
    property p_wsub; warm_reset |-> ##[1:2] (&sub_rst[23:5]); endproperty
    a_wsub: assert property (p_wsub) else $error("warm subsystem reset missed");
    property p_str; $fell(cold_reset) |-> !$past(clock_control_reset, 6); endproperty
    a_str: assert property (p_str) else $error("cold reset not stretched");
    property p_err;
        psel && penable && paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0 |->
            pslverr == (paddr > 12'h014);
    endproperty
    a_err: assert property (p_err) else $error("bus error flag wrong");
    property p_safe; branch_clk[0] == base_clk[0] && !base_idle[0]; endproperty
    a_safe: assert property (p_safe) else $error("safe clock gated");
    property p_glow; !base_clk[1] |-> !(|branch_clk[20:1]); endproperty
    a_glow: assert property (p_glow) else $error("branch high while base low");
endmodule // rbg_props
bind rbg_top rbg_props u_props (.core_clk, .rst_b, .rst_pin_b, .wdt_rst_req, .psel,
    .penable, .paddr, .pslverr, .por_rst, .generator_internal_reset, .clock_control_reset,
    .cold_reset, .warm_reset, .sub_rst, .base_clk, .branch_clk, .base_idle);
`default_nettype wire

// >>> sim/rbg_sub_model.sv
`timescale 1ns/100ps
`default_nettype none
module rbg_sub_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Acknowledge delay
    input wire logic [3:0] lag,
    // Base clocks
    output logic [rbg_pkg::NBASE-1:0] base_clk,
    // Master disable handshake
    input wire logic [rbg_pkg::NBR-1:0] mstr_dis_req,
    output logic [rbg_pkg::NBR-1:0] mstr_dis_ack
);
    logic [3:0] wait_r;
    initial base_clk = '0;
    // Base clocks keep running
    always @(posedge core_clk) base_clk <= ~base_clk;
    // Masters drain, then acknowledge
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 4'h0;
            mstr_dis_ack <= '0;
        end else begin
            wait_r <= (|mstr_dis_req) ? wait_r + 4'(wait_r != 4'hf) : 4'h0;
            mstr_dis_ack <= (wait_r >= lag) ? mstr_dis_req : '0;
        end
    end
endmodule // rbg_sub_model
`default_nettype wire

// >>> sim/tb_reset_and_branch_clock_gating.sv
`timescale 1ns/100ps
`default_nettype none
module tb_reset_and_branch_clock_gating;
    logic core_clk, rst_b, rst_pin_b, wdt_rst_req, wake_evt, psel, penable, pwrite;
    logic pready, pslverr, e, por_rst, generator_internal_reset, clock_control_reset;
    logic cold_reset, warm_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] lag;
    logic [rbg_pkg::NSUB-1:0] sub_rst;
    logic [rbg_pkg::NBASE-1:0] base_clk, base_idle;
    logic [rbg_pkg::NBR-1:0] branch_clk, mstr_dis_req, mstr_dis_ack;
    int bad_count, comparisons;
    rbg_top dut_u (.core_clk, .rst_b, .clk_en(1'b1), .rst_pin_b, .wdt_rst_req, .wake_evt,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_rst,
        .generator_internal_reset, .clock_control_reset, .cold_reset, .warm_reset, .sub_rst,
        .base_clk, .branch_clk, .base_idle, .mstr_dis_req, .mstr_dis_ack);
    rbg_sub_model sub_u (.core_clk, .rst_b, .lag, .base_clk, .mstr_dis_req, .mstr_dis_ack);
    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    function automatic logic [11:0] br(input int i);
        return 12'h100 + 12'(4 * i);
    endfunction
    task automatic settle();
        for (int n = 0; n < 300 && {warm_reset, sub_rst} !== '0; n++) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end
    initial begin
        {rst_b, rst_pin_b, wdt_rst_req, wake_evt, psel, penable, pwrite} = 7'b0100000;
        {paddr, pwdata, lag} = '0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        settle();
        chk(32'({por_rst, generator_internal_reset, clock_control_reset, cold_reset}), 32'h0);
        rd(rbg_pkg::OFF_RST_SRC, 32'h0000_0001);
        rd(12'h018, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, br(0), 32'h0000_0006);
        rd(br(0), 32'h0000_0009);
        apb(1'b1, br(1), 32'h0000_0006);
        rd(br(1), 32'h0000_000f);
        apb(1'b1, br(4), 32'h0000_0000);
        rd(br(4), 32'h0000_0000);
        apb(1'b1, br(40), 32'h0000_0000);
        rd(rbg_pkg::OFF_BASE_STAT, 32'h0000_0020);
        repeat (2) begin
            @(posedge core_clk);
            chk(32'(branch_clk[40]), 32'h0000_0000);
        end
        lag <= 4'h6;
        apb(1'b1, br(41), 32'h0000_0002);
        rd(br(41), 32'h0000_000a);
        chk(32'(mstr_dis_req[41]), 32'h0000_0001);
        repeat (12) @(posedge core_clk);
        rd(br(41), 32'h0000_0002);
        chk(32'(mstr_dis_req[41]), 32'h0000_0000);
        apb(1'b1, br(43), 32'h0000_0005);
        apb(1'b1, rbg_pkg::OFF_PD_CTRL, 32'h0000_0001);
        rd(br(43), 32'h0000_0005);
        rd(br(44), 32'h0000_0009);
        wake_evt <= 1'b1;
        repeat (3) @(posedge core_clk);
        wake_evt <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(br(43), 32'h0000_000d);
        rd(rbg_pkg::OFF_PD_CTRL, 32'h0000_0000);
        apb(1'b1, rbg_pkg::OFF_RST_CTRL, 32'h0000_0080);
        repeat (3) @(posedge core_clk);
        chk(32'(sub_rst), 32'h0000_0000);
        apb(1'b1, rbg_pkg::OFF_RST_KEY, rbg_pkg::RST_KEY_VAL);
        apb(1'b1, rbg_pkg::OFF_RST_CTRL, 32'h0000_0080);
        repeat (3) @(posedge core_clk);
        chk(32'(sub_rst), 32'h0000_0080);
        settle();
        rd(rbg_pkg::OFF_RST_SRC, 32'h0000_0009);
        apb(1'b1, rbg_pkg::OFF_RST_SRC, 32'h0000_000f);
        wdt_rst_req <= 1'b1;
        @(posedge core_clk);
        wdt_rst_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(32'({warm_reset, sub_rst}), 32'h01ff_ffff);
        settle();
        rd(rbg_pkg::OFF_RST_SRC, 32'h0000_0004);
        rd(br(4), 32'h0000_0009);
        rst_pin_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk(32'(generator_internal_reset), 32'h0000_0001);
        rst_pin_b <= 1'b1;
        settle();
        stop_test();
    end
endmodule // tb_reset_and_branch_clock_gating
`default_nettype wire
